// ---- src/fspd_cmd.v ----
// Command interpreter for suspend/resume, deep power-down and ID reads.
// Assumes host drives select, serial clock and IO0/IO1; all are sampled
// with two flops on clk. Array engine is outside: it reports opStart.
`include "fspd_defs.vh"
`timescale 1ns/1ns
`default_nettype none
module fspd_cmd #(
    parameter [7:0] MFG_ID = 8'h5a, // Arbitrary value
    parameter [7:0] DEV_ID = 8'h15  // Arbitrary value
) (
    input  wire       clk,
    input  wire       arst_n,
    input  wire       csPin_n,
    input  wire       sckPin,
    input  wire       io0In,
    input  wire       io1In,
    output reg        io0Out,
    output reg        io0Oe,
    output reg        io1Out,
    output reg        io1Oe,
    input  wire       opStart,
    input  wire [1:0] opKind,
    input  wire       opDone,
    output reg        busyFlag,
    output reg        suspendFlag,
    output reg        powerDown,
    output reg        opPause,
    output reg        opRun,
    output reg        cmdReject
);

////////////////////////////////////////////////////////////////////////////
// Input synchronisers; first stage feeds only the second
reg [1:0] csSync_q;
reg [1:0] sckSync_q;
reg [1:0] io0Sync_q;
reg [1:0] io1Sync_q;
reg       sckLast_q;
always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        csSync_q  <= 2'h3;
        sckSync_q <= 2'h0;
        io0Sync_q <= 2'h0;
        io1Sync_q <= 2'h0;
        sckLast_q <= 1'b0;
    end else begin
        csSync_q  <= {csSync_q[0], csPin_n};
        sckSync_q <= {sckSync_q[0], sckPin};
        io0Sync_q <= {io0Sync_q[0], io0In};
        io1Sync_q <= {io1Sync_q[0], io1In};
        sckLast_q <= sckSync_q[1];
    end
end

wire csHigh  = csSync_q[1];
wire sckRise = !csHigh && sckSync_q[1] && !sckLast_q;
wire sckFall = !csHigh && !sckSync_q[1] && sckLast_q;

////////////////////////////////////////////////////////////////////////////
// Frame decoder state
localparam [2:0] ST_OPC   = 3'h0;
localparam [2:0] ST_ADDR  = 3'h1;
localparam [2:0] ST_ID    = 3'h2;
localparam [2:0] ST_SKIP  = 3'h3;
localparam [2:0] ST_DUAL  = 3'h4;

reg [2:0]  state_q;
reg [7:0]  shift_q;
reg [5:0]  bitCnt_q;   // Bits (or bit pairs) taken in this phase
reg [7:0]  opcode_q;
reg        opcDone_q;  // Eight opcode bits latched
reg        extra_q;    // Clock rise seen after the opcode
reg [15:0] idShift_q;
reg        idSingle_q; // Device-ID only, byte repeats
reg        csHighLast_q;

// Whether an opcode is refused by the current suspend state
function refused;
    input [7:0] op;
    input       susp;
    input [1:0] kind;
    begin
        refused = 1'b0;
        if (susp && op == `FSPD_OP_WRSR)
            refused = 1'b1;
        if (susp && kind == `FSPD_OPK_ERASE &&
            (op == `FSPD_OP_SE || op == `FSPD_OP_BE32 ||
             op == `FSPD_OP_BE64 || op == `FSPD_OP_CE1 ||
             op == `FSPD_OP_CE2 || op == `FSPD_OP_SRER))
            refused = 1'b1;
        if (susp && kind == `FSPD_OPK_PROG &&
            (op == `FSPD_OP_PP || op == `FSPD_OP_QPP ||
             op == `FSPD_OP_SRPP))
            refused = 1'b1;
    end
endfunction

wire [7:0] opcNext = {shift_q[6:0], io0Sync_q[1]};
wire       csRise  = csHigh && !csHighLast_q;

////////////////////////////////////////////////////////////////////////////
// Status and operation control
reg [1:0]  curKind_q;
reg [11:0] timer_q;     // Suspend latch, resume busy, power-down timing
reg        susPend_q;   // Suspend accepted, busy still high
reg        dpPend_q;    // Power-down entry under way
reg        relPend_q;   // Release under way
reg        resPend_q;   // Resume accepted, busy not yet set

wire       blocked = powerDown || relPend_q || dpPend_q;

////////////////////////////////////////////////////////////////////////////
// Timer loads, cut to the timer width on purpose.
// The timer is shared between the pending actions: only one of suspend,
// resume, power-down entry and release can be waiting at any time, except an
// entry taken while a resume waits, which reloads the timer so both fire together;
// one down-counter serves them all and saves three separate counters.
// Resume and entry load one less than the count: the action fires on the
// edge at which the timer reads zero, one edge after its last decrement.
// Release loads the full count so that its limit is never undercut.
localparam integer RESUME_LOAD = `FSPD_RESUME_CYC - 1;
localparam integer DP_LOAD     = `FSPD_DP_CYC - 1;
localparam integer RES1_LOAD   = `FSPD_RES1_CYC;
localparam integer RES2_LOAD   = `FSPD_RES2_CYC;
localparam [11:0]  RESUME_T    = RESUME_LOAD[11:0];
localparam [11:0]  DP_T        = DP_LOAD[11:0];
localparam [11:0]  RES1_T      = RES1_LOAD[11:0];
localparam [11:0]  RES2_T      = RES2_LOAD[11:0];

// Commands end at select rise; single-byte commands need exactly 8 bits
wire endOne   = csRise && opcDone_q && !extra_q;
wire doSusp   = endOne && opcode_q == `FSPD_OP_SUSP && !blocked &&
                !suspendFlag && busyFlag && !susPend_q &&
                curKind_q != `FSPD_OPK_CHIP;
wire doResume = endOne && opcode_q == `FSPD_OP_RESUME && !blocked &&
                suspendFlag && !busyFlag;
wire doPdown  = endOne && opcode_q == `FSPD_OP_PDOWN && !blocked &&
                !busyFlag;
wire doRel    = csRise && opcDone_q && opcode_q == `FSPD_OP_RELEASE &&
                powerDown && !relPend_q;
wire relId    = extra_q;

always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        busyFlag     <= 1'b0;
        suspendFlag  <= 1'b0;
        powerDown    <= 1'b0;
        opPause      <= 1'b0;
        opRun        <= 1'b0;
        cmdReject    <= 1'b0;
        curKind_q    <= `FSPD_OPK_NONE;
        timer_q      <= 12'h000;
        susPend_q    <= 1'b0;
        dpPend_q     <= 1'b0;
        relPend_q    <= 1'b0;
        resPend_q    <= 1'b0;
        csHighLast_q <= 1'b1;
    end else begin
        csHighLast_q <= csHigh;
        opPause   <= 1'b0;
        opRun     <= 1'b0;
        cmdReject <= 1'b0;
        if (timer_q != 12'h000)
            timer_q <= timer_q - 12'h001;
        // Start of a self-timed cycle; any start while suspended is dropped whole
        if (opStart && !busyFlag && !blocked && !suspendFlag) begin
            busyFlag  <= 1'b1;
            curKind_q <= opKind;
        end else if (opStart && suspendFlag &&
                     refused(8'h00, 1'b0, opKind) == 1'b0 &&
                     !busyFlag && !blocked) begin
            busyFlag <= busyFlag;
        end
        if (opDone && busyFlag && !susPend_q) begin
            busyFlag  <= 1'b0;
            curKind_q <= `FSPD_OPK_NONE;
        end
        // Suspend: flag now, busy drops after the latency
        if (doSusp) begin
            suspendFlag <= 1'b1;
            susPend_q   <= 1'b1;
            opPause     <= 1'b1;
            timer_q     <= 12'h010;
        end
        if (susPend_q && timer_q == 12'h000) begin
            susPend_q <= 1'b0;
            busyFlag  <= 1'b0;
        end
        // Resume: flag now, busy back within the resume limit
        if (doResume) begin
            suspendFlag <= 1'b0;
            resPend_q   <= 1'b1;
            timer_q     <= RESUME_T;
        end
        if (resPend_q && timer_q == 12'h000) begin
            resPend_q <= 1'b0;
            busyFlag  <= 1'b1;
            opRun     <= 1'b1;
        end
        // Power-down entry and release
        if (doPdown) begin
            dpPend_q <= 1'b1;
            timer_q  <= DP_T;
        end
        if (dpPend_q && timer_q == 12'h000) begin
            dpPend_q  <= 1'b0;
            powerDown <= 1'b1;
        end
        if (doRel) begin
            relPend_q <= 1'b1;
            timer_q   <= relId ? RES2_T : RES1_T;
        end
        if (relPend_q && timer_q == 12'h000) begin
            relPend_q <= 1'b0;
            powerDown <= 1'b0;
        end
        // Report opcodes refused by the suspend state
        if (csRise && opcDone_q && !blocked &&
            refused(opcode_q, suspendFlag, curKind_q))
            cmdReject <= 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////////
// Serial frame: opcode, address or dummies, then ID shifting
always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        state_q    <= ST_OPC;
        shift_q    <= 8'h00;
        bitCnt_q   <= 6'h00;
        opcode_q   <= 8'h00;
        opcDone_q  <= 1'b0;
        extra_q    <= 1'b0;
        idShift_q  <= 16'h0000;
        idSingle_q <= 1'b0;
        io0Out     <= 1'b0;
        io0Oe      <= 1'b0;
        io1Out     <= 1'b0;
        io1Oe      <= 1'b0;
    end else if (csHigh) begin
        state_q   <= ST_OPC;
        bitCnt_q  <= 6'h00;
        opcDone_q <= opcDone_q && !csRise ? 1'b1 : 1'b0;
        extra_q   <= extra_q && !csRise ? 1'b1 : 1'b0;
        io0Oe     <= 1'b0;
        io1Oe     <= 1'b0;
    end else begin
        case (state_q)
        ST_OPC: if (sckRise) begin
            shift_q  <= opcNext;
            bitCnt_q <= bitCnt_q + 6'h01;
            if (bitCnt_q == 6'h07) begin
                opcode_q  <= opcNext;
                opcDone_q <= 1'b1;
                bitCnt_q  <= 6'h00;
                // Busy or powered down: ID reads are not served
                if (busyFlag || blocked)
                    state_q <= ST_SKIP;
                else if (opcNext == `FSPD_OP_RELEASE ||
                         opcNext == `FSPD_OP_MFID)
                    state_q <= ST_ADDR;
                else if (opcNext == `FSPD_OP_MFID2)
                    state_q <= ST_DUAL;
                else
                    state_q <= ST_SKIP;
            end
        end
        ST_ADDR: if (sckRise) begin
            extra_q  <= 1'b1;
            bitCnt_q <= bitCnt_q + 6'h01;
            if (bitCnt_q == 6'h17) begin
                state_q    <= ST_ID;
                idSingle_q <= opcode_q == `FSPD_OP_RELEASE;
                idShift_q  <= opcode_q == `FSPD_OP_RELEASE ?
                              {DEV_ID, DEV_ID} : {MFG_ID, DEV_ID};
            end
        end
        ST_DUAL: if (sckRise) begin
            extra_q  <= 1'b1;
            bitCnt_q <= bitCnt_q + 6'h01;
            // Twelve pairs of address, four pairs of mode byte
            if (bitCnt_q == 6'h0f) begin
                state_q    <= ST_ID;
                idSingle_q <= 1'b0;
                idShift_q  <= {MFG_ID, DEV_ID};
                bitCnt_q   <= 6'h3f;
            end
        end
        ST_ID: if (sckFall) begin
            if (opcode_q == `FSPD_OP_MFID2) begin
                io0Oe     <= 1'b1;
                io1Oe     <= 1'b1;
                io1Out    <= idShift_q[15];
                io0Out    <= idShift_q[14];
                idShift_q <= {idShift_q[13:0], idShift_q[15:14]};
            end else begin
                io1Oe     <= 1'b1;
                io1Out    <= idShift_q[15];
                idShift_q <= {idShift_q[14:0], idShift_q[15]};
            end
        end
        default: begin
            extra_q <= extra_q | sckRise;
        end
        endcase
    end
end

endmodule
`default_nettype wire

// ---- src/fspd_defs.vh ----
// Constants for the suspend / power-down / identification command block.
// Assumes inclusion by the command interpreter; definitions only.
`ifndef FSPD_DEFS_VH
`define FSPD_DEFS_VH
`define FSPD_OP_WRSR     8'h01
`define FSPD_OP_PP       8'h02
`define FSPD_OP_QPP      8'h32
`define FSPD_OP_SRPP     8'h42
`define FSPD_OP_SE       8'h20
`define FSPD_OP_BE32     8'h52
`define FSPD_OP_BE64     8'hd8
`define FSPD_OP_CE1      8'hc7
`define FSPD_OP_CE2      8'h60
`define FSPD_OP_SRER     8'h44
`define FSPD_OP_SUSP     8'h75
`define FSPD_OP_RESUME   8'h7a
`define FSPD_OP_PDOWN    8'hb9
`define FSPD_OP_RELEASE  8'hab
`define FSPD_OP_MFID     8'h90
`define FSPD_OP_MFID2    8'h92
// Operation kinds of the self-timed engine
`define FSPD_OPK_NONE    2'h0
`define FSPD_OPK_ERASE   2'h1
`define FSPD_OPK_CHIP    2'h2
`define FSPD_OPK_PROG    2'h3
// Timing, ns, and the clock period
`define FSPD_CLK_NS      10
`define FSPD_SUS_NS      20000
`define FSPD_RESUME_NS   200
`define FSPD_DP_NS       3000
`define FSPD_RES1_NS     3000
`define FSPD_RES2_NS     1800
// Longest times round down, least times round up
`define FSPD_SUS_CYC     (`FSPD_SUS_NS / `FSPD_CLK_NS)
`define FSPD_RESUME_CYC  (`FSPD_RESUME_NS / `FSPD_CLK_NS)
`define FSPD_DP_CYC      (`FSPD_DP_NS / `FSPD_CLK_NS)
`define FSPD_RES1_CYC    ((`FSPD_RES1_NS + `FSPD_CLK_NS - 1) / `FSPD_CLK_NS)
`define FSPD_RES2_CYC    ((`FSPD_RES2_NS + `FSPD_CLK_NS - 1) / `FSPD_CLK_NS)
`endif

// ---- dv/fspd_cmd_chk.sv ----
// Checker for fspd_cmd: suspend, resume, power-down and ID drive timing.
// Assumes the bind below; watches only the command block's ports.
`timescale 1ns/1ns
`default_nettype none
module fspd_cmd_chk (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic csPin_n,
    input wire logic io0Oe,
    input wire logic io1Oe,
    input wire logic opStart,
    input wire logic opDone,
    input wire logic busyFlag,
    input wire logic suspendFlag,
    input wire logic powerDown,
    input wire logic opPause,
    input wire logic opRun,
    input wire logic cmdReject
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////////////////////////////////////
    // Suspend is only taken from a busy, unsuspended engine
    AST_SUS_GATE: assert property (
        opPause |-> $past(busyFlag) && !$past(suspendFlag))
        else $error("suspend taken in wrong state");
    AST_SUS_SET: assert property (
        opPause |-> suspendFlag) else $error("suspend flag late");
    AST_BUSY_DROP: assert property (
        $rose(suspendFlag) |-> ##[1:30] !busyFlag)
        else $error("busy not cleared after suspend");
    // Resume needs idle busy; busy comes back within 21 cycles of the flag falling
    AST_RES_GATE: assert property (
        $fell(suspendFlag) |-> !$past(busyFlag))
        else $error("resume taken while busy");
    AST_RES_BUSY: assert property (
        $fell(suspendFlag) |-> ##[1:21] busyFlag)
        else $error("busy not set after resume");
    AST_RUN_BUSY: assert property (
        opRun |-> busyFlag && !suspendFlag)
        else $error("resumed op runs without busy");
    // Powered down, no suspend logic may react
    AST_PD_QUIET: assert property (
        powerDown && $past(powerDown) |-> !opPause && !cmdReject)
        else $error("command acted in power-down");
    AST_PWRUP: assert property (
        $rose(arst_n) |-> !powerDown && !suspendFlag && !busyFlag)
        else $error("bad state after power-up");
    // Drive must let go soon after select rises
    AST_OE_OFF: assert property (
        $rose(csPin_n) |-> ##6 !io1Oe && !io0Oe)
        else $error("IO still driven after select rise");
    AST_REJ_STILL: assert property (
        cmdReject |-> $stable(suspendFlag) && $stable(busyFlag))
        else $error("refused opcode moved a flag");
    AST_BUSY_SET: assert property (
        opStart && !busyFlag |-> ##[1:2] busyFlag)
        else $error("busy not set on op start");
    AST_BUSY_END: assert property (
        opDone && busyFlag && !suspendFlag |-> ##[1:2] !busyFlag)
        else $error("busy not cleared on op done");
    // Main scenarios reached
    COV_PAUSE: cover property (opPause);
    COV_RESUME: cover property ($fell(suspendFlag));
    COV_PD: cover property ($rose(powerDown));
    COV_REJ: cover property (cmdReject);
endmodule
bind fspd_cmd fspd_cmd_chk fspd_cmd_chk_i (.clk(clk), .arst_n(arst_n),
    .csPin_n(csPin_n), .io0Oe(io0Oe), .io1Oe(io1Oe), .opStart(opStart),
    .opDone(opDone), .busyFlag(busyFlag), .suspendFlag(suspendFlag),
    .powerDown(powerDown), .opPause(opPause), .opRun(opRun),
    .cmdReject(cmdReject));
`default_nettype wire

// ---- dv/fspd_host.sv ----
// Host controller model: drives select, mode-0 serial clock and IO lines.
// Assumes the device drives IO1 (and IO0 in dual reads) when enabled.
`timescale 1ns/1ns
`default_nettype none
module fspd_host (
    input  wire logic io0Out,
    input  wire logic io0Oe,
    input  wire logic io1Out,
    input  wire logic io1Oe,
    output logic      csPin_n,
    output logic      sckPin,
    output wire logic io0In,
    output wire logic io1In
);
    logic h0 = 1'b0;
    logic h1 = 1'b0;
    logic h1e = 1'b0;
    ////////////////////////////////////////////////////////////////////////
    // Released line shows the inverse of the last level, not a stale copy
    assign io0In = io0Oe ? io0Out : h0;
    assign io1In = io1Oe ? io1Out : (h1e ? h1 : ~io1Out);
    initial begin
        csPin_n = 1'b1;
        sckPin = 1'b0;
    end
    // One rise and fall of the serial clock, 160 ns period
    task pulse(input logic d0, input logic d1, input logic e1);
        begin
            h0 = d0;
            h1 = d1;
            h1e = e1;
            #80 sckPin = 1'b1;
            #80 sckPin = 1'b0;
        end
    endtask
    // One frame: nb opcode bits, address, then nr bits read back
    task xfer(input logic [7:0] op, input integer nb, input integer adr,
              input integer dual, input integer nr, output logic [31:0] rd);
        integer i;
        begin
            rd = 32'h0;
            csPin_n = 1'b0;
            #80;
            for (i = 7; i > 7 - nb; i = i - 1) pulse(op[i], 1'b0, 1'b0);
            for (i = 0; i < (dual ? 16 : adr); i = i + 1)
                pulse(dual != 0 && i >= 12, dual != 0 && i >= 12,
                      dual != 0);
            h1e = 1'b0;
            for (i = 0; i < nr; i = i + 1 + dual) begin
                #70 rd = dual ? {rd[29:0], io1In, io0In} : {rd[30:0], io1In};
                #10 sckPin = 1'b1;
                #80 sckPin = 1'b0;
            end
            #80 csPin_n = 1'b1;
            #200;
        end
    endtask
endmodule
`default_nettype wire

// ---- dv/fspd_cmd_bench.sv ----
// Bench for fspd_cmd: host frames through fspd_host, engine pulses here.
// Assumes a 100 MHz clock and the checker bound to the command block.
`timescale 1ns/1ns
`default_nettype none
module fspd_cmd_bench;
    localparam [7:0] MFG = 8'h3c; // Arbitrary value
    localparam [7:0] DEV = 8'h21; // Arbitrary value
    // Refused opcodes with address bits: seven erase-suspend, four program
    localparam [175:0] RT = {16'h0108, 16'h2018, 16'h5218, 16'hd818,
        16'hc700, 16'h6000, 16'h4418, 16'h0108, 16'h0220, 16'h3220, 16'h4220};
    logic        clk, arst_n, opStart, opDone, rejSeen, oeSeen;
    logic [1:0]  opKind;
    logic [31:0] rd;
    wire         csPin_n, sckPin, io0In, io1In, io0Out, io0Oe, io1Out, io1Oe;
    wire         busyFlag, suspendFlag, powerDown, opPause, opRun, cmdReject;
    integer      errors, tests_run, cyc, i;
    fspd_cmd #(.MFG_ID(MFG), .DEV_ID(DEV)) fspd_cmd_i (.clk(clk),
        .arst_n(arst_n), .csPin_n(csPin_n), .sckPin(sckPin), .io0In(io0In),
        .io1In(io1In), .io0Out(io0Out), .io0Oe(io0Oe), .io1Out(io1Out),
        .io1Oe(io1Oe), .opStart(opStart), .opKind(opKind), .opDone(opDone),
        .busyFlag(busyFlag), .suspendFlag(suspendFlag),
        .powerDown(powerDown), .opPause(opPause), .opRun(opRun),
        .cmdReject(cmdReject));
    fspd_host fspd_host_i (.io0Out(io0Out), .io0Oe(io0Oe), .io1Out(io1Out),
        .io1Oe(io1Oe), .csPin_n(csPin_n), .sckPin(sckPin), .io0In(io0In),
        .io1In(io1In));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Sticky monitors; the hang limit is far above the planned run
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cmdReject) rejSeen <= 1'b1;
        if (io0Oe | io1Oe) oeSeen <= 1'b1;
        if (cyc == 90000) begin
            errors = errors + 1;
            close_out;
        end
    end
    task close_out;
        begin
            if (errors == 0 && tests_run > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task tick(input integer n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask
    // Engine start (done=0) or finish (done=1) pulse, one cycle
    task eng(input logic [1:0] k, input logic done);
        begin
            opStart = !done;
            opDone = done;
            opKind = k;
            tick(1);
            opStart = 1'b0;
            opDone = 1'b0;
        end
    endtask
    task cmd(input logic [7:0] op, input integer nb, input integer adr);
        begin
            fspd_host_i.xfer(op, nb, adr, 0, 0, rd);
            tick(6);
        end
    endtask
    task idr(input logic [7:0] op, input integer dual, input [31:0] exp);
        begin
            fspd_host_i.xfer(op, 8, 24, dual, 32, rd);
            chk(rd, exp);
            tick(6);
        end
    endtask
    // A refused opcode pulses the refusal and keeps the suspension
    task rej(input logic [15:0] e);
        begin
            rejSeen = 1'b0;
            cmd(e[15:8], 8, e[7:0]);
            chk(rejSeen, 1);
            chk(suspendFlag, 1);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {arst_n, opStart, opDone, opKind, rejSeen, oeSeen} = 6'h0;
        {errors, tests_run, cyc} = 0;
        tick(3);
        arst_n = 1'b1;
        tick(3);
        chk({busyFlag, suspendFlag, powerDown}, 0);
        idr(8'hab, 0, {4{DEV}});
        idr(8'h90, 0, {MFG, DEV, MFG, DEV});
        idr(8'h92, 1, {MFG, DEV, MFG, DEV});
        cmd(8'h75, 8, 0);
        chk(suspendFlag, 0);
        eng(2'h1, 0);
        chk(busyFlag, 1);
        cmd(8'h75, 8, 0);
        chk(suspendFlag, 1);
        tick(30);
        chk(busyFlag, 0);
        for (i = 10; i > 3; i = i - 1) rej(RT[16*i +: 16]);
        cmd(8'h7a, 8, 0);
        chk(suspendFlag, 0);
        tick(21);
        chk(busyFlag, 1);
        tick(2000);
        eng(2'h0, 1);
        eng(2'h3, 0);
        cmd(8'h75, 8, 0);
        for (i = 3; i >= 0; i = i - 1) rej(RT[16*i +: 16]);
        arst_n = 1'b0;
        tick(2);
        arst_n = 1'b1;
        tick(3);
        chk(suspendFlag, 0);
        cmd(8'h7a, 8, 0);
        chk({suspendFlag, busyFlag}, 0);
        eng(2'h2, 0);
        cmd(8'h75, 8, 0);
        chk(suspendFlag, 0);
        oeSeen = 1'b0;
        fspd_host_i.xfer(8'h90, 8, 24, 0, 16, rd);
        chk({oeSeen, busyFlag}, 1);
        eng(2'h0, 1);
        cmd(8'hb9, 7, 0);
        tick(320);
        chk(powerDown, 0);
        cmd(8'hb9, 8, 0);
        tick(310);
        chk(powerDown, 1);
        oeSeen = 1'b0;
        fspd_host_i.xfer(8'h90, 8, 24, 0, 16, rd);
        chk(oeSeen, 0);
        cmd(8'hab, 8, 0);
        chk(powerDown, 1);
        tick(310);
        chk(powerDown, 0);
        cmd(8'hb9, 8, 0);
        tick(310);
        fspd_host_i.xfer(8'hab, 8, 24, 0, 16, rd);
        tick(190);
        chk(powerDown, 0);
        close_out;
    end
endmodule
`default_nettype wire
